/* hw/uhc_pkg.sv */
// Purpose: Shared constants and carriers for the host command control block
// Assumes: 125 MHz controller clock, 16-bit command register
// Notes:   Port status bit positions follow the per-port status register
package uhc_pkg;

  // Command register field positions
  localparam int CMD_RUN_BIT      = 0;
  localparam int CMD_SOFT_RST_BIT = 1;
  localparam int CMD_BUS_RST_BIT  = 2;
  localparam int CMD_SUSPEND_BIT  = 3;
  localparam int CMD_RESUME_BIT   = 4;
  localparam int CMD_DEBUG_BIT    = 5;
  localparam int CMD_CFG_FLAG_BIT = 6;
  localparam int CMD_MAXP_BIT     = 7;
  localparam logic [15:0] CMD_RESET_VALUE = 16'h0000;
  localparam logic [15:0] CMD_WRITE_MASK  = 16'h00FF;

  // Per-port status bit positions
  localparam int PSC_CONNECT_BIT     = 0;
  localparam int PSC_CONNECT_CHG_BIT = 1;
  localparam int PSC_ENABLE_BIT      = 2;
  localparam int PSC_ENABLE_CHG_BIT  = 3;
  localparam int PSC_LOW_SPEED_BIT   = 8;
  localparam logic [15:0] PSC_SOFT_RST_MASK = 16'h010F;

  // Timing: full-speed bit time is 83.333 ns, so 64 bit times is ~5333 ns
  localparam int CLK_PERIOD_PS     = 8000;
  localparam int REDETECT_BIT_TIMES = 64;
  localparam int BIT_TIME_PS       = 83333;
  localparam int REDETECT_CYCLES   =
    (REDETECT_BIT_TIMES * BIT_TIME_PS) / CLK_PERIOD_PS;
  // Low-speed end-of-packet lasts 2 low-speed bit times of 666.67 ns
  localparam int LS_EOP_NS         = 1334;
  localparam int LS_EOP_CYCLES     = (LS_EOP_NS * 1000) / CLK_PERIOD_PS;
  // Internal soft reset sequence length
  localparam int SOFT_RST_CYCLES   = 4;

  typedef enum logic [1:0] {
    USB_SIG_IDLE,
    USB_SIG_RESUME,
    USB_SIG_LS_EOP,
    USB_SIG_RESET
  } uhc_bus_sig_e;

  typedef struct packed {
    logic connect;
    logic lowSpeed;
  } uhc_port_line_s;

endpackage

/* hw/uhc_port_redetect.sv */
// Purpose: Per-port status bits touched by controller soft reset
// Assumes: Line state inputs synchronous to sys_clk
// Notes:   Only bits 8 and 3:0 are modelled here
`timescale 1ns/1ps
`default_nettype none
module uhc_port_redetect
  import uhc_pkg::*;
#(
  parameter int REDETECT = REDETECT_CYCLES
)
(
  input  wire logic           sys_clk,
  input  wire logic           reset,
  input  wire logic           softReset,
  input  wire uhc_port_line_s lineState,
  input  wire logic           clearChange,
  output logic [15:0]         portStatus
);

  logic [12:0] settleCount;
  logic        settling;

  // Re-detect roughly 64 bit times after the soft reset bit falls
  always_ff @(posedge sys_clk)
  begin
    if (reset || softReset)
    begin
      settleCount <= 13'(REDETECT);
      settling    <= softReset;
    end
    else if (settling && settleCount != 13'h0000)
      settleCount <= settleCount - 13'h0001;
    else
      settling <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      portStatus <= 16'h0000;
    else if (softReset)
    begin
      // Virtual disconnect disables the port and flags both changes
      portStatus[PSC_CONNECT_BIT]     <= 1'b0;
      portStatus[PSC_ENABLE_BIT]      <= 1'b0;
      portStatus[PSC_CONNECT_CHG_BIT] <= 1'b1;
      portStatus[PSC_ENABLE_CHG_BIT]  <= 1'b1;
      portStatus[PSC_LOW_SPEED_BIT]   <= 1'b0;
    end
    else
    begin
      if (clearChange)
      begin
        portStatus[PSC_CONNECT_CHG_BIT] <= 1'b0;
        portStatus[PSC_ENABLE_CHG_BIT]  <= 1'b0;
      end
      if (!settling)
      begin
        portStatus[PSC_CONNECT_BIT]   <= lineState.connect;
        portStatus[PSC_LOW_SPEED_BIT] <= lineState.lowSpeed;
      end
    end
  end

endmodule
`default_nettype wire

/* hw/uhc_command_ctrl.sv */
// Purpose: Command register control of a two-port host controller
// Assumes: Synchronous register write strobe with byte data on sys_clk
// Notes:   Schedule engine joins through txn start/done and halted flag
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Single-step clears run bit after each transaction
// - Single-step waits for run rewrite before next
// - Force-resume bit drives global resume signalling
// - Suspend plus bus event sets force-resume
// - Resume fall emits LS EOP; bit stays set
// - Suspend blocks transactions, still accepts resume
// - Bus reset drives reset signalling, resets logic
// - Chip reset acts as bus reset, silently
// - Soft reset reinitialises state, aborts transaction
// - Soft reset bit self-clears when sequence done
// - Soft reset touches port bits 8, 3:0 only
// - Soft reset virtual disconnect, sets change bits
// - Ports redetect 64 bit times after soft reset
// - Run bit set keeps schedule executing
// - Run cleared: finish transaction, then halt
// - Fatal errors clear the run bit
// - Halted flag set once stopped
module uhc_command_ctrl
  import uhc_pkg::*;
#(
  parameter int NUM_PORTS = 2
)
(
  input  wire logic                 sys_clk,
  input  wire logic                 reset,
  input  wire logic                 cmdWrite,
  input  wire logic [15:0]          cmdWriteData,
  input  wire logic                 txnDone,
  input  wire logic                 txnWanted,
  input  wire logic                 consistencyError,
  input  wire logic                 pciBusError,
  input  wire logic                 busResumeEvent,
  input  wire uhc_port_line_s [NUM_PORTS-1:0] portLine,
  input  wire logic                 portChangeClear,
  output logic [15:0]               hostCommand,
  output logic                      halted_flag,
  output logic                      txnStart,
  output logic                      txnAbort,
  output logic                      resumeReceived,
  output uhc_bus_sig_e              busSignal,
  output logic [NUM_PORTS-1:0][15:0] portStatus
);

  logic       inTxn;
  logic [7:0] eopCount;
  logic [2:0] softCount;
  logic       softActive;
  logic       logicReset;
  logic       resumeFall;

  function automatic logic cmdBit(input logic [15:0] v, input int pos);
    return v[pos];
  endfunction

  // Bus-wide reset holds all logic in reset; chip reset does the same
  assign logicReset = reset || hostCommand[CMD_BUS_RST_BIT];
  assign softActive = hostCommand[CMD_SOFT_RST_BIT];
  // Software clear of force-resume is caught at the write itself, so the
  // bit never reads zero before the end-of-packet has run, except for a clear written while soft reset is active
  assign resumeFall = cmdWrite && !cmdBit(cmdWriteData, CMD_RESUME_BIT) &&
                      hostCommand[CMD_RESUME_BIT] && eopCount == 8'h00 &&
                      !softActive && !hostCommand[CMD_BUS_RST_BIT];

  // Command register
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      hostCommand <= CMD_RESET_VALUE;
    else if (hostCommand[CMD_BUS_RST_BIT])
    begin
      // Only software may release the bus reset bit
      hostCommand <= CMD_RESET_VALUE | (16'h0004);
      if (cmdWrite && !cmdBit(cmdWriteData, CMD_BUS_RST_BIT))
        hostCommand <= CMD_RESET_VALUE;
    end
    else
    begin
      if (cmdWrite)
      begin
        hostCommand <= cmdWriteData & CMD_WRITE_MASK;
        // Force-resume stays one until the end-of-packet finishes
        if ((eopCount != 8'h00 || resumeFall) &&
            !cmdBit(cmdWriteData, CMD_RESUME_BIT))
          hostCommand[CMD_RESUME_BIT] <= 1'b1;
      end
      if (softActive && softCount == 3'h0 &&
          !(cmdWrite && cmdBit(cmdWriteData, CMD_SOFT_RST_BIT)))
        hostCommand[CMD_SOFT_RST_BIT] <= 1'b0;
      if (softActive)
        hostCommand[CMD_RUN_BIT] <= 1'b0;
      // Single-step clear of run loses to a same-cycle write; software rewrite restarts
      if (consistencyError || pciBusError)
        hostCommand[CMD_RUN_BIT] <= 1'b0;
      else if (txnDone && hostCommand[CMD_DEBUG_BIT] && !cmdWrite)
        hostCommand[CMD_RUN_BIT] <= 1'b0;
      if (eopCount > 8'h01)
        hostCommand[CMD_RESUME_BIT] <= 1'b1;
      else if (eopCount == 8'h01)
        hostCommand[CMD_RESUME_BIT] <= 1'b0;
      // A wake event set wins over the end-of-packet clear
      if (hostCommand[CMD_SUSPEND_BIT] && busResumeEvent)
        hostCommand[CMD_RESUME_BIT] <= 1'b1;
    end
  end

  // Soft reset sequence length
  always_ff @(posedge sys_clk)
  begin
    if (logicReset)
      softCount <= 3'(SOFT_RST_CYCLES);
    else if (!softActive)
      softCount <= 3'(SOFT_RST_CYCLES);
    else if (softCount != 3'h0)
      softCount <= softCount - 3'h1;
  end

  // Resume edge and low-speed EOP timer
  always_ff @(posedge sys_clk)
  begin
    if (logicReset || softActive)
    begin
      eopCount <= 8'h00;
    end
    else
    begin
      if (resumeFall)
        eopCount <= 8'(LS_EOP_CYCLES);
      else if (eopCount != 8'h00)
        eopCount <= eopCount - 8'h01;
    end
  end

  // Transaction engine handshake
  always_ff @(posedge sys_clk)
  begin
    if (logicReset)
    begin
      inTxn    <= 1'b0;
      txnStart <= 1'b0;
      txnAbort <= 1'b0;
    end
    else if (softActive)
    begin
      inTxn    <= 1'b0;
      txnStart <= 1'b0;
      txnAbort <= inTxn;
    end
    else
    begin
      txnAbort <= 1'b0;
      txnStart <= 1'b0;
      if (inTxn && txnDone)
        inTxn <= 1'b0;
      else if (!inTxn && txnWanted && hostCommand[CMD_RUN_BIT] &&
               !hostCommand[CMD_SUSPEND_BIT] && !txnStart)
      begin
        inTxn    <= 1'b1;
        txnStart <= 1'b1;
      end
    end
  end

  // Halted once stopped with nothing in flight
  always_ff @(posedge sys_clk)
  begin
    if (logicReset)
      halted_flag <= 1'b1;
    else
      halted_flag <= !hostCommand[CMD_RUN_BIT] && !inTxn &&
                     !(txnStart);
  end

  // Resume from the bus is still seen during suspend
  always_ff @(posedge sys_clk)
  begin
    if (logicReset)
      resumeReceived <= 1'b0;
    else
      resumeReceived <= hostCommand[CMD_SUSPEND_BIT] && busResumeEvent;
  end

  // Line signalling priority: reset, end-of-packet, resume
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      busSignal <= USB_SIG_IDLE;
    else if (hostCommand[CMD_BUS_RST_BIT])
      busSignal <= USB_SIG_RESET;
    else if (hostCommand[CMD_RESUME_BIT] && eopCount == 8'h00 &&
             !resumeFall)
      busSignal <= USB_SIG_RESUME;
    else if (eopCount != 8'h00 || resumeFall)
      busSignal <= USB_SIG_LS_EOP;
    else
      busSignal <= USB_SIG_IDLE;
  end

  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++)
    begin : gen_port
      uhc_port_redetect u_port (
        .sys_clk     (sys_clk),
        .reset       (logicReset),
        .softReset   (softActive),
        .lineState   (portLine[p]),
        .clearChange (portChangeClear),
        .portStatus  (portStatus[p])
      );
    end
  endgenerate

  a_step_clears_run: assert property (@(posedge sys_clk) disable iff (reset)
    txnDone && inTxn && hostCommand[CMD_DEBUG_BIT] && !cmdWrite &&
    !hostCommand[CMD_BUS_RST_BIT] |=> !hostCommand[CMD_RUN_BIT])
    else $error("Run bit not cleared after single step");
  a_no_start_stopped: assert property (@(posedge sys_clk) disable iff (reset)
    txnStart |-> $past(hostCommand[CMD_RUN_BIT]))
    else $error("Transaction started while stopped");
  a_resume_drive: assert property (@(posedge sys_clk) disable iff (reset)
    hostCommand[CMD_RESUME_BIT] && eopCount == 8'h00 && !resumeFall &&
    !hostCommand[CMD_BUS_RST_BIT] |=> busSignal == USB_SIG_RESUME)
    else $error("Resume not driven");
  a_wake_event: assert property (@(posedge sys_clk) disable iff (reset)
    hostCommand[CMD_SUSPEND_BIT] && busResumeEvent &&
    !hostCommand[CMD_BUS_RST_BIT] |=> hostCommand[CMD_RESUME_BIT])
    else $error("Bus event did not set force-resume");
  a_eop_holds_bit: assert property (@(posedge sys_clk) disable iff (reset)
    resumeFall && !softActive |=> hostCommand[CMD_RESUME_BIT] [*2])
    else $error("Force-resume fell before end-of-packet");
  a_suspend_no_txn: assert property (@(posedge sys_clk) disable iff (reset)
    txnStart |-> !$past(hostCommand[CMD_SUSPEND_BIT]))
    else $error("Transaction in suspend");
  a_bus_reset_sig: assert property (@(posedge sys_clk) disable iff (reset)
    hostCommand[CMD_BUS_RST_BIT] |=> busSignal == USB_SIG_RESET)
    else $error("Reset signalling missing");
  a_soft_selfclear: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(softActive) && !hostCommand[CMD_BUS_RST_BIT] && !cmdWrite
    |-> ##[1:8] !softActive)
    else $error("Soft reset bit never cleared");
  a_fatal_stop: assert property (@(posedge sys_clk) disable iff (reset)
    pciBusError || consistencyError |=> !hostCommand[CMD_RUN_BIT])
    else $error("Fatal error left run set");
  a_halted_flag: assert property (@(posedge sys_clk) disable iff (reset)
    !hostCommand[CMD_RUN_BIT] && !inTxn && !txnStart |=> halted_flag)
    else $error("Halted flag not set when stopped");

  c_single_step: cover property (@(posedge sys_clk)
    hostCommand[CMD_DEBUG_BIT] && txnStart ##[1:20] txnDone);
  c_resume_eop: cover property (@(posedge sys_clk)
    resumeFall ##1 busSignal == USB_SIG_LS_EOP);
  c_soft_reset: cover property (@(posedge sys_clk) $fell(softActive));
  c_fatal: cover property (@(posedge sys_clk) pciBusError && inTxn);
  c_bus_reset: cover property (@(posedge sys_clk) $fell(logicReset));

  // Soft reset side effects on the transaction engine
  a_abort_on_soft: assert property (@(posedge sys_clk) disable iff (reset)
    softActive && inTxn |=> txnAbort)
    else $error("Transaction not aborted by soft reset");
  a_soft_no_start: assert property (@(posedge sys_clk) disable iff (reset)
    softActive |=> !txnStart)
    else $error("Transaction started during soft reset");
  a_soft_stops_run: assert property (@(posedge sys_clk) disable iff (reset)
    softActive |=> !hostCommand[CMD_RUN_BIT])
    else $error("Run bit survived soft reset");
  a_abort_pulse: assert property (@(posedge sys_clk) disable iff (reset)
    txnAbort |=> !txnAbort)
    else $error("Abort longer than one cycle");

  // End-of-packet after a software clear of force-resume
  a_eop_signal: assert property (@(posedge sys_clk) disable iff (reset)
    eopCount != 8'h00 && !hostCommand[CMD_BUS_RST_BIT]
    |=> busSignal == USB_SIG_LS_EOP)
    else $error("End-of-packet not driven");
  a_eop_bit_set: assert property (@(posedge sys_clk) disable iff (reset)
    eopCount > 8'h01 && !hostCommand[CMD_BUS_RST_BIT]
    |=> hostCommand[CMD_RESUME_BIT])
    else $error("Force-resume dropped during end-of-packet");
  a_eop_bit_ends: assert property (@(posedge sys_clk) disable iff (reset)
    eopCount == 8'h01 && !hostCommand[CMD_BUS_RST_BIT] &&
    !(hostCommand[CMD_SUSPEND_BIT] && busResumeEvent)
    |=> !hostCommand[CMD_RESUME_BIT])
    else $error("Force-resume stuck after end-of-packet");

  // Schedule execution and halting
  a_run_starts: assert property (@(posedge sys_clk) disable iff (reset)
    hostCommand[CMD_RUN_BIT] && !inTxn && txnWanted && !txnStart &&
    !hostCommand[CMD_SUSPEND_BIT] && !softActive &&
    !hostCommand[CMD_BUS_RST_BIT] |=> txnStart)
    else $error("Running controller did not start a transaction");
  a_start_pulse: assert property (@(posedge sys_clk) disable iff (reset)
    txnStart |=> !txnStart)
    else $error("Start longer than one cycle");
  a_txn_finishes: assert property (@(posedge sys_clk) disable iff (reset)
    inTxn && !txnDone && !softActive && !hostCommand[CMD_BUS_RST_BIT]
    |=> inTxn)
    else $error("Transaction dropped before done");
  a_busy_not_halt: assert property (@(posedge sys_clk) disable iff (reset)
    inTxn && !hostCommand[CMD_BUS_RST_BIT] |=> !halted_flag)
    else $error("Halted while a transaction is in flight");
  a_halt_needs_stop: assert property (@(posedge sys_clk) disable iff (reset)
    halted_flag && !$past(logicReset)
    |-> !$past(hostCommand[CMD_RUN_BIT]))
    else $error("Halted flag set while running");

  // Resets and register readback
  a_bus_reset_hold: assert property (@(posedge sys_clk) disable iff (reset)
    hostCommand[CMD_BUS_RST_BIT] &&
    !(cmdWrite && !cmdWriteData[CMD_BUS_RST_BIT])
    |=> hostCommand == 16'h0004)
    else $error("Bus reset bit not held");
  a_bus_reset_idle: assert property (@(posedge sys_clk) disable iff (reset)
    hostCommand[CMD_BUS_RST_BIT] |=> halted_flag && !txnStart)
    else $error("Logic not held in bus reset");
  a_chip_reset: assert property (@(posedge sys_clk)
    reset |=> hostCommand == CMD_RESET_VALUE && halted_flag &&
    busSignal == USB_SIG_IDLE)
    else $error("Chip reset state wrong");
  a_readback: assert property (@(posedge sys_clk) disable iff (reset)
    cmdWrite && !hostCommand[CMD_BUS_RST_BIT]
    |=> hostCommand[15:6] == {8'h00, $past(cmdWriteData[7:6])})
    else $error("Written bits did not read back");
  a_resume_quiet: assert property (@(posedge sys_clk) disable iff (reset)
    !hostCommand[CMD_SUSPEND_BIT] |=> !resumeReceived)
    else $error("Resume reported outside suspend");

endmodule
`default_nettype wire

/* tb/uhc_usb_dev_model.sv */
// Purpose: Far-side model of attached devices and schedule traffic
// Assumes: Transactions finish after a chosen latency unless aborted
// Notes:   Resume event is a one-cycle pulse per kReq rise
`timescale 1ns/1ps
`default_nettype none
module uhc_usb_dev_model
  import uhc_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 txnStart,
  input  wire logic                 txnAbort,
  input  wire logic [7:0]           latency,
  input  wire logic                 attach,
  input  wire logic                 lowSp,
  input  wire logic                 kReq,
  output logic                      txnDone = 1'b0,
  output logic                      busResumeEvent = 1'b0,
  output uhc_port_line_s [1:0]      portLine
);
  int   cnt   = 0;
  logic kLast = 1'b0;
  // An aborted transaction never reports done
  always @(posedge sys_clk)
  begin
    txnDone <= 1'b0;
    if (txnAbort)
      cnt <= 0;
    else if (txnStart)
      cnt <= int'(latency) + 1;
    else if (cnt == 1)
    begin
      txnDone <= 1'b1;
      cnt     <= 0;
    end
    else if (cnt > 1)
      cnt <= cnt - 1;
    busResumeEvent <= kReq & ~kLast;
    kLast          <= kReq;
  end
  assign portLine[0] = '{connect: attach, lowSpeed: lowSp};
  assign portLine[1] = '{connect: attach, lowSpeed: 1'b0};
endmodule
`default_nettype wire

/* tb/usb_host_command_control_test.sv */
// Purpose: Self-checking bench for the host command control block
// Assumes: Partner model answers transactions
// Notes:   Notes are queued by the driver, checked by a monitor
`timescale 1ns/1ps
`default_nettype none
module usb_host_command_control_test;
  import uhc_pkg::*;
  typedef struct packed {
    logic [2:0]  sel;
    logic [15:0] msk;
    logic [15:0] val;
  } uhc_note_s;
  logic sys_clk = 0, reset = 1, cmdWrite = 0, txnWanted = 0;
  logic consistencyError = 0, pciBusError = 0, portChangeClear = 0;
  logic attach = 1, lowSp = 1, kReq = 0, chk = 0, abortSeen = 0;
  logic resumeSeen = 0;
  logic [7:0]  latency = 8'h03;
  logic [15:0] cmdWriteData = 16'h0000, starts = 16'h0000;
  logic [15:0] hostCommand, got, d, s0;
  logic halted_flag, txnStart, txnAbort, resumeReceived;
  logic txnDone, busResumeEvent;
  uhc_bus_sig_e busSignal;
  logic [1:0][15:0] portStatus;
  uhc_port_line_s [1:0] portLine;
  uhc_note_s n;
  uhc_note_s notes[$];
  int failures = 0, tests_run = 0;

  always #4 sys_clk = ~sys_clk;

  uhc_command_ctrl dut_u (.sys_clk(sys_clk), .reset(reset),
    .cmdWrite(cmdWrite), .cmdWriteData(cmdWriteData), .txnDone(txnDone),
    .txnWanted(txnWanted), .consistencyError(consistencyError),
    .pciBusError(pciBusError), .busResumeEvent(busResumeEvent),
    .portLine(portLine), .portChangeClear(portChangeClear),
    .hostCommand(hostCommand), .halted_flag(halted_flag),
    .txnStart(txnStart), .txnAbort(txnAbort),
    .resumeReceived(resumeReceived), .busSignal(busSignal),
    .portStatus(portStatus));
  uhc_usb_dev_model dev_u (.sys_clk(sys_clk), .txnStart(txnStart),
    .txnAbort(txnAbort), .latency(latency), .attach(attach),
    .lowSp(lowSp), .kReq(kReq), .txnDone(txnDone),
    .busResumeEvent(busResumeEvent), .portLine(portLine));

  always @(posedge sys_clk)
  begin
    starts <= starts + 16'(txnStart);
    if (txnAbort === 1'b1)
      abortSeen <= 1'b1;
    if (resumeReceived === 1'b1)
      resumeSeen <= 1'b1;
  end

  // Monitor samples at the falling edge, clear of launch races
  always @(negedge sys_clk)
  begin
    if (chk && notes.size() > 0)
    begin
      n = notes.pop_front();
      case (n.sel)
        3'd0: got = hostCommand;
        3'd1: got = {15'h0, halted_flag};
        3'd2: got = {14'h0, busSignal};
        3'd3: got = portStatus[0];
        3'd4: got = starts;
        3'd5: got = {15'h0, abortSeen};
        default: got = {15'h0, resumeSeen};
      endcase
      tests_run++;
      if ((got & n.msk) !== n.val)
      begin
        failures++;
        $display("FAIL t=%0t exp=%h got=%h", $time, n.val, got & n.msk);
      end
    end
  end

  task automatic note(input logic [2:0] s, input logic [15:0] v,
                      input logic [15:0] m = 16'hFFFF);
    @(posedge sys_clk);
    notes.push_back({s, m, v});
    chk <= 1'b1;
    @(posedge sys_clk);
    chk <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] v);
    @(posedge sys_clk);
    cmdWrite     <= 1'b1;
    cmdWriteData <= v;
    @(posedge sys_clk);
    cmdWrite <= 1'b0;
  endtask
  task automatic waitc(input int c);
    repeat (c) @(posedge sys_clk);
  endtask
  task automatic done(input string s);
    $display("Test %s finished", s);
  endtask
  task results;
    $display("Checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    void'($urandom(32'h9fbc));
    waitc(10);
    reset <= 1'b0;
    note(0, 16'h0000);
    note(1, 16'h0001);
    note(2, 16'(USB_SIG_IDLE));
    note(6, 16'h0000);
    done("reset");
    repeat (4)
    begin
      d = 16'($urandom);
      wr(d & 16'hFFC0);
      note(0, d & 16'h00C0);
    end
    wr(16'h0000);
    done("readback");
    txnWanted <= 1'b1;
    latency   <= 8'($urandom_range(20, 1));
    wr(16'h0001);
    waitc(30);
    note(1, 16'h0000);
    wr(16'h0000);
    waitc(30);
    note(1, 16'h0001);
    done("run stop");
    s0 = starts;
    wr(16'h0021);
    waitc(40);
    note(0, 16'h0020);
    note(4, s0 + 16'h0001);
    note(1, 16'h0001);
    wr(16'h0021);
    waitc(40);
    note(4, s0 + 16'h0002);
    txnWanted <= 1'b0;
    wr(16'h0000);
    done("single step");
    for (int i = 0; i < 2; i++)
    begin
      wr(16'h0001);
      waitc(2);
      consistencyError <= (i == 0);
      pciBusError      <= (i == 1);
      waitc(1);
      consistencyError <= 1'b0;
      pciBusError      <= 1'b0;
      waitc(25);
      note(0, 16'h0000);
      note(1, 16'h0001);
    end
    done("fatal");
    txnWanted <= 1'b1;
    s0 = starts;
    wr(16'h0008);
    waitc(20);
    note(4, s0);
    kReq <= 1'b1;
    waitc(6);
    kReq <= 1'b0;
    note(0, 16'h0018);
    note(2, 16'(USB_SIG_RESUME));
    note(6, 16'h0001);
    wr(16'h0008);
    waitc(2);
    note(0, 16'h0018);
    note(2, 16'(USB_SIG_LS_EOP));
    waitc(LS_EOP_CYCLES - 12);
    note(0, 16'h0018);
    waitc(10);
    note(0, 16'h0008);
    note(2, 16'(USB_SIG_IDLE));
    wr(16'h0000);
    done("suspend resume");
    latency <= 8'd200;
    wr(16'h0001);
    waitc(10);
    wr(16'h0002);
    waitc(12);
    note(5, 16'h0001);
    note(0, 16'h0000);
    note(3, 16'h000A, 16'h010F);
    waitc(REDETECT_CYCLES);
    note(3, 16'h0101, 16'h0101);
    portChangeClear <= 1'b1;
    waitc(1);
    portChangeClear <= 1'b0;
    note(3, 16'h0000, 16'h000A);
    done("soft reset");
    wr(16'h0004);
    waitc(3);
    note(2, 16'(USB_SIG_RESET));
    note(0, 16'h0004);
    wr(16'h0000);
    waitc(3);
    note(1, 16'h0001);
    note(2, 16'(USB_SIG_IDLE));
    done("bus reset");
    waitc(5);
    results;
  end

  // Whole run is about 1200 cycles; the 20000-cycle limit leaves ample margin
  initial
  begin
    #(8 * 20000);
    failures++;
    results;
  end
endmodule
`default_nettype wire
